// ===== common/icf_pkg.sv
package icf_pkg;

  // Arithmetic flags kept by the core
  typedef struct packed {
    logic cy;
    logic ac;
    logic ov;
  } icf_flags_type;

  // One program byte request
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } icf_pmem_req_type;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_OPC  = 4'b0010,
    ST_OPND = 4'b0100,
    ST_ADDR = 4'b1000
  } icf_state_type;

endpackage

// ===== common/icf_regs.svh
`ifndef ICF_REGS_SVH
`define ICF_REGS_SVH

// Register byte offsets on the bus
`define ICF_OFS_CTRL      8'h00
`define ICF_OFS_PC        8'h04
`define ICF_OFS_FLAGS     8'h08
`define ICF_OFS_STATUS    8'h0C
`define ICF_OFS_MAIN      8'hE0
`define ICF_OFS_SEC       8'hF0
// Working bank: eight words from 0x40, selected by offset bits 7:5
`define ICF_BANK_SEL      3'b010

// Field positions
`define ICF_CTRL_RUN      0
`define ICF_FLAG_CY       7
`define ICF_FLAG_AC       6
`define ICF_FLAG_OV       2

// Reset values
`define ICF_RST_BYTE      8'h00
`define ICF_RST_PC        16'h0000

// Timing
`define ICF_CLKS_PER_MC   4
`define ICF_JUMP_EXTRA_MC 1

// Opcodes and opcode fields
`define ICF_OP_NOP        8'h00
`define ICF_OP_LJMP       8'h02
`define ICF_OP_SJMP       8'h80
`define ICF_OP_AJMP_LO    5'h01
`define ICF_OP_RRC        8'h13
`define ICF_OP_RLC        8'h33
`define ICF_OP_DIV        8'h84
`define ICF_OP_MUL        8'hA4
`define ICF_OP_CPLC       8'hB3
`define ICF_OP_CLRC       8'hC3
`define ICF_OP_SETBC      8'hD3
`define ICF_OP_DA         8'hD4
`define ICF_OP_CLRA       8'hE4
`define ICF_OP_CPLA       8'hF4
`define ICF_OP_ADD_IMM    8'h24
`define ICF_HI_ADD        4'h2
`define ICF_HI_ADDC       4'h3
`define ICF_HI_SUBB       4'h9
`define ICF_LO_IMM        4'h4
`define ICF_LO_DIR        4'h5
`define ICF_LO_IND0       4'h6
`define ICF_LO_IND1       4'h7

`endif

// ===== hw/icf_core.sv
`timescale 1ns/1ps
`include "icf_regs.svh"
// What this block does
// - Machine cycle equals four clock periods
// - At most one program fetch per cycle
// - One machine cycle per instruction byte
// - Jumps add one address cycle
// - Main arithmetic register at E0h
// - Secondary register, multiply and divide operand
// - Standard operation and flag effects kept
// - Add family sets all; multiply/divide carry and overflow; others carry only
// - Multiply/divide clear carry; carry clear/set forced
// - NOP one cycle; immediate add two

module icf_core (
  // Clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // AHB-Lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic [31:0]                   hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  // Program memory
  output icf_pkg::icf_pmem_req_type     pmem_req,
  input  wire logic [7:0]               pmem_data,
  // Datapath view
  output logic [7:0]                    main_arith_reg,
  output icf_pkg::icf_flags_type        flags
);

  // Machine-cycle timing
  logic [1:0]              phase;     // Clock within machine cycle
  logic                    mc_begin;  // First clock of a cycle
  logic                    mc_end;    // Last clock of a cycle
  // Sequencer
  icf_pkg::icf_state_type  state;     // Current state
  icf_pkg::icf_state_type  next_state;
  logic [7:0]              opcode;    // Captured opcode
  logic [7:0]              opnd1;     // First operand byte
  logic [7:0]              opnd_last; // Latest fetched byte
  logic [1:0]              fetched;   // Bytes fetched so far
  logic [2:0]              mc_count;  // Cycles spent in instruction
  logic [15:0]             pc;        // Program address
  logic [15:0]             retired;   // Instructions completed
  logic [15:0]             jump_target;
  logic [7:0]              cur_op;    // Opcode of the instruction in hand
  logic                    fetching;
  logic                    fetch_end;
  logic                    fetch_done;
  logic                    retire;
  logic                    exec_arith;
  logic                    jump_exec;
  // Registers and datapath
  logic                    run;       // Fetch enable from software
  logic [7:0]              secondary_arith_reg;
  logic [7:0]              bank [0:7]; // Working registers
  logic [7:0]              opnd;      // Selected ALU operand
  logic [7:0]              alu_res;
  icf_pkg::icf_flags_type  alu_fl;
  logic [7:0]              next_main;
  logic [7:0]              next_sec;
  icf_pkg::icf_flags_type  next_fl;
  // Bus
  logic                    bus_take;  // Address phase accepted
  logic                    wr_pend;   // Write data phase in progress
  logic [7:0]              wr_addr;   // Offset of pending write
  logic [31:0]             rd_mux;
  logic                    wr_ctrl;
  logic                    wr_pc;
  logic                    wr_flags;
  logic                    wr_main;
  logic                    wr_sec;

  // Instruction length in bytes
  function automatic logic [1:0] instr_len(input logic [7:0] op);
    if (op == `ICF_OP_LJMP) begin
      return 2'd3;
    end
    if (op == `ICF_OP_SJMP || op[4:0] == `ICF_OP_AJMP_LO) begin
      return 2'd2;
    end
    if (is_arith(op) && (op[3:0] == `ICF_LO_IMM || op[3:0] == `ICF_LO_DIR)) begin
      return 2'd2;
    end
    return 2'd1;
  endfunction

  // Jumps that need the extra address cycle
  function automatic logic is_jump(input logic [7:0] op);
    return op == `ICF_OP_LJMP || op == `ICF_OP_SJMP || op[4:0] == `ICF_OP_AJMP_LO;
  endfunction

  // Add, add-with-carry and subtract-with-borrow forms
  function automatic logic is_arith(input logic [7:0] op);
    return (op[7:4] == `ICF_HI_ADD || op[7:4] == `ICF_HI_ADDC || op[7:4] == `ICF_HI_SUBB)
           && (op[3:0] >= `ICF_LO_IMM);
  endfunction

  // Offsets that land in the working bank
  function automatic logic in_bank(input logic [7:0] ofs);
    return ofs[7:5] == `ICF_BANK_SEL;
  endfunction

  icf_mc_timer #(
    .CLKS_PER_MC (`ICF_CLKS_PER_MC)
  ) u_timer (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .phase    (phase),
    .mc_begin (mc_begin),
    .mc_end   (mc_end)
  );

  // Sequencing terms
  always_comb begin
    fetching   = (state == icf_pkg::ST_OPC) || (state == icf_pkg::ST_OPND);
    cur_op     = (state == icf_pkg::ST_OPC) ? pmem_data : opcode;
    fetch_end  = mc_end && fetching;
    fetch_done = (fetched + 2'd1) == instr_len(cur_op);
    jump_exec  = mc_end && (state == icf_pkg::ST_ADDR);
    retire     = (fetch_end && fetch_done && !is_jump(cur_op)) || jump_exec;
    exec_arith = retire && !jump_exec;
  end

  // Next state, evaluated only on the last clock of a cycle
  always_comb begin
    next_state = state;
    if (mc_end) begin
      unique case (state)
        icf_pkg::ST_IDLE: begin
          if (run) begin
            next_state = icf_pkg::ST_OPC;
          end
        end
        icf_pkg::ST_OPC, icf_pkg::ST_OPND: begin
          if (!fetch_done) begin
            next_state = icf_pkg::ST_OPND;
          end else if (is_jump(cur_op)) begin
            next_state = icf_pkg::ST_ADDR;
          end else begin
            next_state = run ? icf_pkg::ST_OPC : icf_pkg::ST_IDLE;
          end
        end
        icf_pkg::ST_ADDR: begin
          next_state = run ? icf_pkg::ST_OPC : icf_pkg::ST_IDLE;
        end
        default: begin
          next_state = icf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // State, opcode and operand capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= icf_pkg::ST_IDLE;
      opcode    <= `ICF_RST_BYTE;
      opnd1     <= `ICF_RST_BYTE;
      opnd_last <= `ICF_RST_BYTE;
      fetched   <= '0;
    end else begin
      state <= next_state;
      if (fetch_end) begin
        opnd_last <= pmem_data;
        fetched   <= fetch_done ? 2'd0 : fetched + 2'd1;
        if (state == icf_pkg::ST_OPC) begin
          opcode <= pmem_data;
        end
        if (fetched == 2'd1) begin
          opnd1 <= pmem_data;
        end
      end
    end
  end

  // Cycle and instruction counters; only the instruction count is in the status word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mc_count <= '0;
      retired  <= '0;
    end else if (mc_end && state != icf_pkg::ST_IDLE) begin
      mc_count <= retire ? 3'd0 : mc_count + 3'd1;
      if (retire) begin
        retired <= retired + 16'd1;
      end
    end
  end

  // New address for the three jump forms
  always_comb begin
    if (opcode == `ICF_OP_LJMP) begin
      jump_target = {opnd1, opnd_last};
    end else if (opcode == `ICF_OP_SJMP) begin
      jump_target = pc + {{8{opnd_last[7]}}, opnd_last};
    end else begin
      jump_target = {pc[15:11], opcode[7:5], opnd_last};
    end
  end

  // Program counter; a software write wins over the sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc <= `ICF_RST_PC;
    end else if (wr_pc) begin
      pc <= hwdata[15:0];
    end else if (fetch_end) begin
      pc <= pc + 16'd1;
    end else if (jump_exec) begin
      pc <= jump_target;
    end
  end

  // One request on the first clock of a fetching cycle only
  assign pmem_req.rd   = mc_begin && fetching;
  assign pmem_req.addr = pc;

  // Operand select: immediate, direct, indirect or bank register
  always_comb begin
    case (cur_op[3:0])
      `ICF_LO_IMM: begin
        opnd = pmem_data;
      end
      `ICF_LO_DIR: begin
        if (pmem_data == `ICF_OFS_MAIN) begin
          opnd = main_arith_reg;
        end else if (pmem_data == `ICF_OFS_SEC) begin
          opnd = secondary_arith_reg;
        end else begin
          opnd = bank[pmem_data[2:0]];
        end
      end
      `ICF_LO_IND0, `ICF_LO_IND1: begin
        opnd = bank[bank[{2'b00, cur_op[0]}][2:0]];
      end
      default: begin
        opnd = bank[cur_op[2:0]];
      end
    endcase
  end

  icf_flag_alu u_alu (
    .opa    (main_arith_reg),
    .opb    (opnd),
    .cin    ((cur_op[7:4] == `ICF_HI_ADD) ? 1'b0 : flags.cy),
    .sub    (cur_op[7:4] == `ICF_HI_SUBB),
    .res    (alu_res),
    .fl_out (alu_fl)
  );

  // Results of the executing instruction
  always_comb begin
    logic [15:0] prod;
    logic [8:0]  da;
    prod      = {8'h00, main_arith_reg} * {8'h00, secondary_arith_reg};
    da        = {1'b0, main_arith_reg};
    next_main = main_arith_reg;
    next_sec  = secondary_arith_reg;
    next_fl   = flags;
    if (is_arith(cur_op)) begin
      next_main = alu_res;
      next_fl   = alu_fl;
    end else begin
      case (cur_op)
        `ICF_OP_MUL: begin
          {next_sec, next_main} = prod;
          next_fl.cy = 1'b0;
          next_fl.ov = (prod[15:8] != 8'h00);
        end
        `ICF_OP_DIV: begin
          next_fl.cy = 1'b0;
          next_fl.ov = (secondary_arith_reg == 8'h00);
          if (secondary_arith_reg != 8'h00) begin
            next_main = main_arith_reg / secondary_arith_reg;
            next_sec  = main_arith_reg % secondary_arith_reg;
          end
        end
        `ICF_OP_DA: begin
          if (flags.ac || main_arith_reg[3:0] > 4'h9) begin
            da = da + 9'h006;
          end
          if (flags.cy || da[8] || da[7:4] > 4'h9) begin
            da = da + 9'h060;
            next_fl.cy = 1'b1;
          end
          next_main = da[7:0];
        end
        `ICF_OP_RRC: begin
          {next_main, next_fl.cy} = {flags.cy, main_arith_reg};
        end
        `ICF_OP_RLC: begin
          {next_fl.cy, next_main} = {main_arith_reg, flags.cy};
        end
        `ICF_OP_CLRC: begin
          next_fl.cy = 1'b0;
        end
        `ICF_OP_SETBC: begin
          next_fl.cy = 1'b1;
        end
        `ICF_OP_CPLC: begin
          next_fl.cy = ~flags.cy;
        end
        `ICF_OP_CLRA: begin
          next_main = `ICF_RST_BYTE;
        end
        `ICF_OP_CPLA: begin
          next_main = ~main_arith_reg;
        end
        default: begin
          next_main = main_arith_reg; // NOP and unsupported codes change nothing
        end
      endcase
    end
  end

  // Arithmetic registers; a bus write in the same cycle takes priority
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_arith_reg      <= `ICF_RST_BYTE;
      secondary_arith_reg <= `ICF_RST_BYTE;
    end else begin
      if (wr_main) begin
        main_arith_reg <= hwdata[7:0];
      end else if (exec_arith) begin
        main_arith_reg <= next_main;
      end
      if (wr_sec) begin
        secondary_arith_reg <= hwdata[7:0];
      end else if (exec_arith) begin
        secondary_arith_reg <= next_sec;
      end
    end
  end

  // Flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= '0;
    end else if (wr_flags) begin
      flags.cy <= hwdata[`ICF_FLAG_CY];
      flags.ac <= hwdata[`ICF_FLAG_AC];
      flags.ov <= hwdata[`ICF_FLAG_OV];
    end else if (exec_arith) begin
      flags <= next_fl;
    end
  end

  // Bus address phase; zero wait states, always OKAY
  assign bus_take  = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_ctrl   = wr_pend && (wr_addr == `ICF_OFS_CTRL);
  assign wr_pc     = wr_pend && (wr_addr == `ICF_OFS_PC);
  assign wr_flags  = wr_pend && (wr_addr == `ICF_OFS_FLAGS);
  assign wr_main   = wr_pend && (wr_addr == `ICF_OFS_MAIN);
  assign wr_sec    = wr_pend && (wr_addr == `ICF_OFS_SEC);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= bus_take && hwrite;
      if (bus_take) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  // Control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run <= 1'b0;
    end else if (wr_ctrl) begin
      run <= hwdata[`ICF_CTRL_RUN];
    end
  end

  // Working bank written by software only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 8; i++) begin
        bank[i] <= `ICF_RST_BYTE;
      end
    end else if (wr_pend && in_bank(wr_addr)) begin
      bank[wr_addr[4:2]] <= hwdata[7:0];
    end
  end

  // Read mux; hsize is ignored since only whole words are used
  always_comb begin
    rd_mux = '0;
    if (in_bank(haddr[7:0])) begin
      rd_mux[7:0] = bank[haddr[4:2]];
    end else begin
      case (haddr[7:0])
        `ICF_OFS_CTRL:   rd_mux[`ICF_CTRL_RUN] = run;
        `ICF_OFS_PC:     rd_mux[15:0] = pc;
        `ICF_OFS_FLAGS: begin
          rd_mux[`ICF_FLAG_CY] = flags.cy;
          rd_mux[`ICF_FLAG_AC] = flags.ac;
          rd_mux[`ICF_FLAG_OV] = flags.ov;
        end
        `ICF_OFS_STATUS: rd_mux = {retired, opcode, 2'b00, phase, state};
        `ICF_OFS_MAIN:   rd_mux[7:0] = main_arith_reg;
        `ICF_OFS_SEC:    rd_mux[7:0] = secondary_arith_reg;
        default:         rd_mux = '0;
      endcase
    end
  end

  // Read data registered at the address phase, held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (bus_take && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [2:0] exp_mc; // Cycles the instruction in hand must take
  assign exp_mc = {1'b0, instr_len(cur_op)} + (is_jump(cur_op) ? 3'd`ICF_JUMP_EXTRA_MC : 3'd0);

  a_one_fetch: assert property (pmem_req.rd |=> !pmem_req.rd [*3])
    else $error("more than one fetch in a machine cycle");
  a_instr_cycles: assert property (retire |-> (mc_count + 3'd1) == exp_mc)
    else $error("instruction cycle count differs from its length");
  a_jump_extra: assert property (retire && is_jump(cur_op) |-> state == icf_pkg::ST_ADDR ##0
                                  mc_count == {1'b0, instr_len(opcode)})
    else $error("jump missed its address cycle");
  a_add_result: assert property (exec_arith && is_arith(cur_op) && !wr_main |=>
                                  main_arith_reg == $past(alu_res))
    else $error("add result not in main register");
  a_rot_carry: assert property (exec_arith && (cur_op == `ICF_OP_RRC || cur_op == `ICF_OP_RLC) && !wr_flags
                                 |=> $stable(flags.ov) && $stable(flags.ac))
    else $error("rotate touched overflow or auxiliary carry");
  a_mul_flags: assert property (exec_arith && cur_op == `ICF_OP_MUL && !wr_flags && !wr_sec
                                 |=> !flags.cy && $stable(flags.ac) && flags.ov == (secondary_arith_reg != 8'h00))
    else $error("multiply flags wrong");
  a_clr_carry: assert property (exec_arith && cur_op == `ICF_OP_CLRC && !wr_flags |=> !flags.cy)
    else $error("clear carry left carry set");
  a_nop_time: assert property (retire && cur_op == `ICF_OP_NOP |-> mc_count == 3'd0 && mc_end)
    else $error("no-operation took more than one cycle");
  a_imm_time: assert property (retire && cur_op == `ICF_OP_ADD_IMM |-> mc_count == 3'd1)
    else $error("immediate add did not take two cycles");

endmodule

// ===== hw/icf_flag_alu.sv
`timescale 1ns/1ps

module icf_flag_alu (
  // Operands
  input  wire logic [7:0]          opa,
  input  wire logic [7:0]          opb,
  input  wire logic                cin,
  input  wire logic                sub,
  // Result and flags
  output logic [7:0]               res,
  output icf_pkg::icf_flags_type   fl_out
);

  logic [7:0] bx;   // Operand, inverted for subtract
  logic       ci;   // Carry in, inverted for borrow
  logic [4:0] lo;   // Low nibble sum
  logic [8:0] full; // Full sum with carry out

  // Subtract is add of the complement; borrows are inverted carries
  always_comb begin
    bx   = sub ? ~opb : opb;
    ci   = sub ? ~cin : cin;
    lo   = {1'b0, opa[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
    full = {1'b0, opa} + {1'b0, bx} + {8'h00, ci};
    res  = full[7:0];
    fl_out.cy = full[8] ^ sub;
    fl_out.ac = lo[4] ^ sub;
    fl_out.ov = (opa[7] == bx[7]) && (full[7] != opa[7]);
  end

endmodule

// ===== hw/icf_mc_timer.sv
`timescale 1ns/1ps
`include "icf_regs.svh"

module icf_mc_timer #(
  parameter int CLKS_PER_MC = `ICF_CLKS_PER_MC
) (
  // Clock and reset
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  // Machine-cycle timing
  output logic [$clog2(CLKS_PER_MC)-1:0]      phase,
  output logic                                mc_begin,
  output logic                                mc_end
);

  localparam int PW = $clog2(CLKS_PER_MC);
  localparam logic [PW-1:0] LAST = PW'(CLKS_PER_MC - 1);

  // Free-running phase counter; never stalls so every cycle is whole
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= '0;
    end else if (phase == LAST) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  // One-cycle enables at the ends of each machine cycle
  assign mc_begin = (phase == '0);
  assign mc_end   = (phase == LAST);

  sequence s_mc_gap;
    !mc_begin [*3] ##1 mc_begin;
  endsequence

  a_mc_period: assert property (@(posedge hclk) disable iff (!hresetn) mc_begin |=> s_mc_gap)
    else $error("machine cycle is not four clocks");

endmodule

// ===== verif/icf_prog_mem.sv
`timescale 1ns/1ps

// Program memory model: one byte per fetch strobe, no back pressure
module icf_prog_mem (
  // Clock
  input  wire logic                      hclk,
  // Fetch request and program image
  input  wire icf_pkg::icf_pmem_req_type pmem_req,
  input  wire logic [255:0]              prog,
  // Returned byte
  output logic [7:0]                     pmem_data
);
  logic [1:0] hold;  // Cycles the byte still stands

  initial pmem_data = 8'h5A;
  initial hold = 2'h0;

  // Byte stands until the core samples it, then goes stale so a late
  // sample cannot match by luck
  always @(posedge hclk) begin
    if (pmem_req.rd === 1'b1) begin
      pmem_data <= prog[8*pmem_req.addr[4:0] +: 8];
      hold      <= 2'h3;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else begin
      pmem_data <= ~pmem_data;
    end
  end
endmodule

// ===== verif/instruction_cycle_flag_unit_test.sv
`timescale 1ns/1ps
`include "icf_regs.svh"

module instruction_cycle_flag_unit_test;
  // Clock, reset and bus master side
  logic                      hclk    = 1'b0;
  logic                      hresetn = 1'b0;
  logic                      hsel    = 1'b0;
  logic [31:0]               haddr   = 32'h0;
  logic [1:0]                htrans  = 2'h0;
  logic                      hwrite  = 1'b0;
  logic [2:0]                hsize   = 3'h2;
  logic [31:0]               hwdata  = 32'h0;
  logic [31:0]               hrdata;
  logic                      hreadyout;
  logic                      hresp;
  // Fetch link and datapath view
  icf_pkg::icf_pmem_req_type pmem_req;
  logic [7:0]                pmem_data;
  logic [7:0]                main_arith_reg;
  icf_pkg::icf_flags_type    flags;
  // Program: ADD #7F, NOP, SETB C, ADDC #80, CLR C, CPL C, RLC, SETB C, MUL, SJMP self
  logic [255:0]              prog = {152'h0, 104'hFE80A4D333B3C38034D3007F24};
  // Fetch log
  logic [15:0]               f_addr [0:63];
  int                        f_cyc [0:63];
  int                        nf = 0;
  int                        cyc = 0;
  int                        n_fail = 0;
  int                        comparisons = 0;
  logic [31:0]               rd;

  // 25 MHz clock
  always #20 hclk = ~hclk;

  icf_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pmem_req(pmem_req), .pmem_data(pmem_data),
    .main_arith_reg(main_arith_reg), .flags(flags));

  icf_prog_mem pmem (.hclk(hclk), .pmem_req(pmem_req), .prog(prog), .pmem_data(pmem_data));

  // Log every fetch strobe with its cycle number
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (pmem_req.rd === 1'b1 && nf < 64) begin
      f_addr[nf] <= pmem_req.addr;
      f_cyc[nf]  <= cyc;
      nf         <= nf + 1;
    end
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB transfer; waits on ready, never assumes latency
  task automatic ahb(input logic wr_en, input logic [7:0] ofs, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, ofs};
    hwrite <= wr_en;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    ahb(1'b1, ofs, d);
  endtask

  task automatic rdchk(input logic [7:0] ofs, input logic [31:0] exp);
    ahb(1'b0, ofs, 32'h0);
    check(rd, exp);
  endtask

  // Run from address 0 until n fetches are logged, stop, confirm the core idles
  task automatic run_to(input int n);
    int k;
    wr(`ICF_OFS_PC, 32'h0);
    wr(`ICF_OFS_CTRL, 32'h1);
    for (k = 0; k < 400 && nf < n; k++) @(posedge hclk);
    wr(`ICF_OFS_CTRL, 32'h0);
    repeat (16) @(posedge hclk);
    k = nf;
    repeat (12) @(posedge hclk);
    check(32'(nf), 32'(k));
  endtask

  // Single place where the run ends
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  initial begin
    int i;
    int k;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    check({24'h0, main_arith_reg}, 32'h0);
    check({29'h0, flags}, 32'h0);
    rdchk(`ICF_OFS_MAIN, 32'h0);
    rdchk(`ICF_OFS_SEC, 32'h0);
    // Registers keep only their low byte; unmapped space reads zero
    wr(`ICF_OFS_MAIN, 32'h5A5A5AC3);
    rdchk(`ICF_OFS_MAIN, 32'h000000C3);
    wr(`ICF_OFS_SEC, 32'h0000013C);
    rdchk(`ICF_OFS_SEC, 32'h0000003C);
    wr(8'h80, 32'hFFFFFFFF);
    rdchk(8'h80, 32'h0);
    // Set operands, then run the program from address 0
    wr(`ICF_OFS_MAIN, 32'h01);
    wr(`ICF_OFS_SEC, 32'h90);
    wr(`ICF_OFS_FLAGS, 32'h40);
    run_to(17);
    // Flag and register results of the whole program
    check({24'h0, main_arith_reg}, 32'hB0);
    rdchk(`ICF_OFS_MAIN, 32'hB0);
    rdchk(`ICF_OFS_SEC, 32'h01);
    check({29'h0, flags}, 32'h1);
    rdchk(`ICF_OFS_FLAGS, 32'h04);
    // Fetch order and spacing: one byte per 4 clocks, jump adds one cycle
    for (i = 0; i < 16; i++) begin
      check({16'h0, f_addr[i]}, 32'((i < 13) ? i : ((i % 2 == 1) ? 11 : 12)));
      if (i > 0) begin
        check(32'(f_cyc[i] - f_cyc[i-1]), 32'((i == 13 || i == 15) ? 8 : 4));
      end
    end
    // LJMP 0005, SUBB A,40h, ADD A,@R0, ADDC A,R0, DA, DIV, RRC, CPL A, SUBB #F8, AJMP 12h, SJMP self
    prog <= {96'h0, 160'hFE80001201F894F41384D4382640950000050002};
    wr(`ICF_OFS_MAIN, 32'h15);
    wr(`ICF_OFS_SEC, 32'h04);
    wr(8'h40, 32'h01);
    wr(8'h44, 32'h27);
    wr(`ICF_OFS_FLAGS, 32'h0);
    k = nf;
    run_to(k + 17);
    // Borrow sets carry and auxiliary carry; divide leaves the remainder
    rdchk(`ICF_OFS_MAIN, 32'hFF);
    rdchk(`ICF_OFS_SEC, 32'h02);
    rdchk(`ICF_OFS_FLAGS, 32'hC0);
    // LJMP and AJMP each add one address cycle with no fetch
    for (i = 0; i < 17; i++) begin
      check({16'h0, f_addr[k+i]}, 32'(i + ((i >= 3) ? 2 : 0) + ((i >= 15) ? 1 : 0)));
      if (i > 0) begin
        check(32'(f_cyc[k+i] - f_cyc[k+i-1]), 32'((i == 3 || i == 15) ? 8 : 4));
      end
    end
    print_verdict();
  end
endmodule
